// file: hdl/oel_event_latch.sv
// oel_event_latch: sticky dual-role port event flags behind an apb slave
// assumes timer_timeout comes from logic on mclk; port pins are asynchronous
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "oel_map.svh"

module oel_event_latch
    import oel_pkg::*;
#(
    parameter logic [`OEL_TMR_W-1:0] SE0_CYCLES  = `OEL_TMR_W'(`OEL_SE0_CYCLES),
    parameter logic [`OEL_TMR_W-1:0] IDLE_CYCLES = `OEL_TMR_W'(`OEL_IDLE_CYCLES)
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire oel_pins_t   pins,
    input  wire logic        timer_timeout,
    output var  logic        irq
);

    // -----------------------------------------------------------------
    // pin synchronisation
    // -----------------------------------------------------------------
    oel_pins_t pins_sync;

    oel_sync u_sync (
        .mclk       (mclk),
        .reset      (reset),
        .pins_async (pins),
        .pins_sync  (pins_sync)
    );

    oel_live_t live;
    oel_live_t live_prev;
    oel_bus_t  bus_now;
    oel_bus_t  bus_prev;
    logic      dp_prev;
    logic      host_sess_prev;
    logic [1:0] prime;
    wire        primed = (prime == `OEL_PRIME_DONE);

    assign live    = pins_sync.live;
    assign bus_now = oel_line_state(pins_sync.line);

    wire dp_now        = pins_sync.line.dp;
    wire host_sess_now = live.host_session_valid;

    // rising edge of a level against its last sample
    function automatic logic rising(input logic now, input logic prev);
        return now && !prev;
    endfunction : rising

    // history regs start at zero, so edges count only once primed;
    // this hides the reset-to-live jump on session end and plug id
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prime <= 2'h0;
        end else if (!primed) begin
            prime <= prime + 2'h1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            live_prev <= `OEL_LIVE_RESET;
        end else begin
            live_prev <= live;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_prev <= OEL_SE0;
        end else begin
            bus_prev <= bus_now;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dp_prev <= 1'b0;
        end else begin
            dp_prev <= dp_now;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            host_sess_prev <= 1'b0;
        end else begin
            host_sess_prev <= host_sess_now;
        end
    end

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    // full byte compare, so no register aliases
    wire setup    = psel && !penable;
    wire access   = psel && penable && pready;
    wire aligned  = (paddr[1:0] == 2'b00);
    wire hit_evr  = aligned && (paddr == `OEL_EVT_RD_ADDR);
    wire hit_evw  = aligned && (paddr == `OEL_EVT_WR_ADDR);
    wire hit_ctrl = aligned && (paddr == `OEL_CTRL_ADDR);
    wire hit_mask = aligned && (paddr == `OEL_MASK_ADDR);
    wire hit_live = aligned && (paddr == `OEL_LIVE_ADDR);

    // the event word has separate read and write codes
    wire rd_ok    = hit_evr || hit_ctrl || hit_mask || hit_live;
    wire wr_ok    = hit_evw || hit_ctrl || hit_mask;
    wire mapped   = pwrite ? wr_ok : rd_ok;

    wire wr_evt   = access && pwrite && hit_evw;
    wire wr_ctrl  = access && pwrite && hit_ctrl;
    wire wr_mask  = access && pwrite && hit_mask;

    // -----------------------------------------------------------------
    // software registers
    // -----------------------------------------------------------------
    oel_flags_t  flags;
    oel_flags_t  next_flags;
    logic [15:0] mask;
    logic        request_kind_select;

    // only implemented flag bits stick in the mask
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mask <= `OEL_MASK_RESET;
        end else if (wr_mask) begin
            mask <= pwdata[15:0] & `OEL_EVT_USED;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            request_kind_select <= `OEL_SEL_RESET;
        end else if (wr_ctrl) begin
            request_kind_select <= pwdata[`OEL_SEL_BIT];
        end
    end

    // -----------------------------------------------------------------
    // duration detectors
    // -----------------------------------------------------------------
    logic se0_long;
    logic se0_long_prev;
    logic idle_long;
    logic idle_long_prev;

    // synced line only: glitches of a clock or two are not filtered
    wire  line_se0 = (bus_now == OEL_SE0);
    wire  line_j   = (bus_now == OEL_J);

    oel_hold_timer #(
        .LIMIT (SE0_CYCLES)
    ) u_se0_timer (
        .mclk  (mclk),
        .reset (reset),
        .hold  (line_se0),
        .over  (se0_long)
    );

    oel_hold_timer #(
        .LIMIT (IDLE_CYCLES)
    ) u_idle_timer (
        .mclk  (mclk),
        .reset (reset),
        .hold  (line_j),
        .over  (idle_long)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            se0_long_prev <= 1'b0;
        end else begin
            se0_long_prev <= se0_long;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            idle_long_prev <= 1'b0;
        end else begin
            idle_long_prev <= idle_long;
        end
    end

    // one event per continuous stretch, not one per cycle
    wire se0_event  = rising(se0_long, se0_long_prev);
    wire idle_event = rising(idle_long, idle_long_prev);

    // -----------------------------------------------------------------
    // suspend tracking
    // -----------------------------------------------------------------
    oel_port_t port_state;
    oel_port_t next_port_state;

    wire j_to_k = (bus_prev == OEL_J) && (bus_now == OEL_K);

    always_comb begin
        next_port_state = port_state;
        unique case (port_state)
            OEL_ACTIVE: begin
                if (idle_event) begin
                    next_port_state = OEL_SUSPENDED;
                end
            end
            OEL_SUSPENDED: begin
                // any non-j sample ends suspend, a glitch included
                if (!line_j) begin
                    next_port_state = OEL_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            port_state <= OEL_ACTIVE;
        end else begin
            port_state <= next_port_state;
        end
    end

    wire suspend_event = (port_state == OEL_ACTIVE) && idle_event;
    wire resume_event  = (port_state == OEL_SUSPENDED) && j_to_k;

    // -----------------------------------------------------------------
    // session request detection
    // -----------------------------------------------------------------
    // select high: bus power pulse; low: data-line pulse.
    // only the leading edge is seen, pulse width is not qualified
    wire bus_power_pulse = primed && rising(host_sess_now, host_sess_prev);
    wire data_line_pulse = primed && rising(dp_now, dp_prev);
    wire srp_event       = request_kind_select ? bus_power_pulse
                                               : data_line_pulse;

    // -----------------------------------------------------------------
    // status change detection
    // -----------------------------------------------------------------
    // no change events until the history is primed
    wire [5:0] live_change = primed ? (live ^ live_prev) : 6'h00;

    // -----------------------------------------------------------------
    // event flags
    // -----------------------------------------------------------------
    oel_flags_t set_vec;
    oel_flags_t clr_vec;

    always_comb begin
        set_vec                                 = '0;
        set_vec.timer_expired_flag              = timer_timeout;
        set_vec.long_single_ended_zero_flag     = se0_event;
        set_vec.session_request_flag            = srp_event;
        set_vec.resume_seen_flag                = resume_event;
        set_vec.suspend_entered_flag            = suspend_event;
        set_vec.remote_pullup_change_flag       = live_change[5];
        set_vec.peripheral_session_valid_change = live_change[4];
        set_vec.host_session_valid_change       = live_change[3];
        set_vec.peripheral_session_end_change   = live_change[2];
        set_vec.host_bus_power_valid_change     = live_change[1];
        set_vec.plug_id_change_flag             = live_change[0];
    end

    // ones clear, zeros keep; reserved bits never stick
    wire [15:0] clr_bits = pwdata[15:0] & `OEL_EVT_USED;
    assign clr_vec = wr_evt ? oel_flags_t'(clr_bits)
                            : oel_flags_t'(16'h0000);

    // a new event in the clearing cycle survives the clear
    assign next_flags = oel_flags_t'((flags & ~clr_vec) | set_vec);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags <= `OEL_EVT_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // -----------------------------------------------------------------
    // interrupt
    // -----------------------------------------------------------------
    // from next_flags so irq lines up with the flag register
    wire [15:0] pending = 16'(next_flags) & mask;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |pending;
        end
    end

    // -----------------------------------------------------------------
    // read path and apb answer
    // -----------------------------------------------------------------
    logic [15:0] rd_word;
    wire  [15:0] rd_evt  = 16'(flags);
    wire  [15:0] rd_ctrl = 16'(request_kind_select) << `OEL_SEL_BIT;
    wire  [15:0] rd_live = {10'h000, live};

    assign rd_word = hit_evr  ? rd_evt  :
                     hit_ctrl ? rd_ctrl :
                     hit_mask ? mask    :
                     hit_live ? rd_live :
                                16'h0000;

    // answer fixed at one access cycle; read data frozen at setup
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !mapped;
        end
    end

    // zeroed after each access so a write answer shows no stale data
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= {16'h0000, rd_word};
        end else if (access) begin
            prdata <= 32'h0000_0000;
        end
    end

endmodule : oel_event_latch
`default_nettype wire

// file: hdl/oel_map.svh
// oel_map.svh: register offsets, field positions, reset values, timing counts
// assumes apb byte addressing, one aligned 32-bit word per register, mclk at 20 MHz
//
// Contract
// - event flags read at 68h, written at e8h
// - timer time-out sets flag bit 10
// - write one clears flag, zero keeps it
// - single-ended zero over 2 ms sets bit 9
// - session request pulsing sets flag bit 8
// - control bit 9 selects request detection kind
// - j to k while suspended sets bit 7
// - idle over 3 ms enters suspend, bit 6
`ifndef OEL_MAP_SVH
`define OEL_MAP_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define OEL_EVT_RD_ADDR 8'h68
`define OEL_EVT_WR_ADDR 8'he8
`define OEL_CTRL_ADDR   8'h00
`define OEL_MASK_ADDR   8'h04
`define OEL_LIVE_ADDR   8'h08

// ---------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------
`define OEL_EVT_RESET   16'h0000
`define OEL_EVT_USED    16'h07ff
`define OEL_MASK_RESET  16'h0000
`define OEL_SEL_RESET   1'b0
`define OEL_SEL_BIT     9
`define OEL_LIVE_RESET  6'h00

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define OEL_CLK_KHZ      20000
`define OEL_SE0_TIME_US  2000
`define OEL_IDLE_TIME_US 3000
`define OEL_SE0_CYCLES   ((`OEL_SE0_TIME_US * `OEL_CLK_KHZ + 999) / 1000)
`define OEL_IDLE_CYCLES  ((`OEL_IDLE_TIME_US * `OEL_CLK_KHZ + 999) / 1000)
`define OEL_TMR_W        17
`define OEL_PRIME_DONE   2'h3

`endif

// file: hdl/oel_pkg.sv
// oel_pkg: types shared by the event latch modules
// assumes oel_map.svh is on the include path
`include "oel_map.svh"

package oel_pkg;

    typedef struct packed {
        logic [4:0] rsvd;
        logic       timer_expired_flag;
        logic       long_single_ended_zero_flag;
        logic       session_request_flag;
        logic       resume_seen_flag;
        logic       suspend_entered_flag;
        logic       remote_pullup_change_flag;
        logic       peripheral_session_valid_change;
        logic       host_session_valid_change;
        logic       peripheral_session_end_change;
        logic       host_bus_power_valid_change;
        logic       plug_id_change_flag;
    } oel_flags_t;

    typedef struct packed {
        logic remote_pullup;
        logic periph_session_valid;
        logic host_session_valid;
        logic periph_session_end;
        logic host_bus_power_valid;
        logic plug_id;
    } oel_live_t;

    typedef struct packed {
        logic dp;
        logic dm;
    } oel_line_t;

    typedef struct packed {
        oel_line_t line;
        oel_live_t live;
    } oel_pins_t;

    typedef enum logic [1:0] {
        OEL_SE0 = 2'b00,
        OEL_K   = 2'b01,
        OEL_J   = 2'b10,
        OEL_SE1 = 2'b11
    } oel_bus_t;

    typedef enum logic [0:0] {
        OEL_ACTIVE    = 1'b0,
        OEL_SUSPENDED = 1'b1
    } oel_port_t;

    // full-speed line decode, j is dp high
    function automatic oel_bus_t oel_line_state(input oel_line_t l);
        return oel_bus_t'({l.dp, l.dm});
    endfunction : oel_line_state

endpackage : oel_pkg

// file: hdl/oel_sync.sv
// oel_sync: two-flop synchroniser bank for the port pins
// assumes pins are quasi-static relative to mclk
`timescale 1ns/1ns
`default_nettype none
`include "oel_map.svh"

module oel_sync
    import oel_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      reset,
    input  wire oel_pins_t pins_async,
    output var  oel_pins_t pins_sync
);

    oel_pins_t stage1;

    // stage1 is read by the second flop only
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stage1    <= '0;
            pins_sync <= '0;
        end else begin
            stage1    <= pins_async;
            pins_sync <= stage1;
        end
    end

endmodule : oel_sync
`default_nettype wire

// file: hdl/oel_hold_timer.sv
// oel_hold_timer: flags a condition held longer than a cycle limit
// assumes a synchronous condition input
`timescale 1ns/1ns
`default_nettype none
`include "oel_map.svh"

module oel_hold_timer
    import oel_pkg::*;
#(
    parameter logic [`OEL_TMR_W-1:0] LIMIT = `OEL_TMR_W'(`OEL_SE0_CYCLES)
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic hold,
    output var  logic over
);

    logic [`OEL_TMR_W-1:0] count;
    logic [`OEL_TMR_W-1:0] next_count;
    wire                   at_limit = (count == LIMIT);

    // saturates so a long hold never wraps into a second event
    assign next_count = !hold   ? '0 :
                        at_limit ? count :
                        count + `OEL_TMR_W'(1);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count <= '0;
            over  <= 1'b0;
        end else begin
            count <= next_count;
            over  <= hold && at_limit;
        end
    end

endmodule : oel_hold_timer
`default_nettype wire

// file: sim/oel_event_latch_props.sv
// oel_event_latch_props: port-level apb and event relations of the latch
// assumes binding onto oel_event_latch, sampling on rising mclk
`timescale 1ns/1ns
`default_nettype none
`include "oel_map.svh"

module oel_event_latch_props
    import oel_pkg::*;
#(
    parameter logic [`OEL_TMR_W-1:0] SE0_CYCLES  = `OEL_TMR_W'(20),
    parameter logic [`OEL_TMR_W-1:0] IDLE_CYCLES = `OEL_TMR_W'(30)
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire oel_pins_t   pins,
    input wire logic        timer_timeout,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [10:0] mask_copy;
    wire         setup   = psel && !penable;
    wire         wr_done = psel && penable && pready && pwrite && !pslverr;

    // shadow of the mask, since the checker cannot see inside
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mask_copy <= 11'h0;
        end else if (wr_done && paddr == 8'h04) begin
            mask_copy <= pwdata[10:0];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_ready_after_setup;
        setup |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray pslverr");
    property p_no_write_at_read_code;
        setup && pwrite && paddr == 8'h68 |=> pslverr;
    endproperty
    a_no_write_at_read_code: assert property (p_no_write_at_read_code)
        else $error("write at read code taken");
    property p_no_read_at_write_code;
        setup && !pwrite && paddr == 8'he8 |=> pslverr && prdata == 32'h0;
    endproperty
    a_no_read_at_write_code: assert property (p_no_read_at_write_code)
        else $error("read at write code taken");
    property p_misaligned;
        setup && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned taken");
    property p_timer_reads_set;
        !$past(reset) && !$past(reset, 2) && $past(timer_timeout, 2)
            && pready && !pwrite && paddr == 8'h68 |-> prdata[10];
    endproperty
    a_timer_reads_set: assert property (p_timer_reads_set) else $error("timer flag lost");
    property p_timer_irq;
        timer_timeout && mask_copy[10] |-> ##[1:3] irq;
    endproperty
    a_timer_irq: assert property (p_timer_irq) else $error("no irq on timer");
    property p_mask_quiet;
        wr_done && paddr == 8'h04 && pwdata[10:0] == 11'h0 |-> ##2 !irq;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("irq with mask off");

    c_timer_irq: cover property (timer_timeout && mask_copy[10]);
    c_refused:   cover property (pready && pslverr);
    c_flag_read: cover property (pready && !pwrite && paddr == 8'h68 && prdata != 32'h0);
endmodule : oel_event_latch_props

bind oel_event_latch oel_event_latch_props #(
    .SE0_CYCLES(SE0_CYCLES),
    .IDLE_CYCLES(IDLE_CYCLES)
) oel_event_latch_props_inst (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .timer_timeout(timer_timeout), .irq(irq)
);
`default_nettype wire

// file: sim/oel_remote.sv
// oel_remote: remote dual-role device driving line and status pins
// assumes one bench process calls its tasks
`timescale 1ns/1ns
`default_nettype none

module oel_remote
    import oel_pkg::*;
(
    input  wire logic      mclk,
    output var  oel_pins_t pins
);
    // lines are always driven here, no released state to model
    initial begin
        pins = {2'b01, 6'h00};
    end

    // k to j raises dp, the data-line pulse; j to k is resume
    task automatic line_set(input oel_bus_t s);
        @(posedge mclk);
        pins.line <= oel_line_t'(s);
    endtask : line_set

    // one status indication changes value
    task automatic live_flip(input int i);
        @(posedge mclk);
        pins.live[i] <= !pins.live[i];
    endtask : live_flip
endmodule : oel_remote
`default_nettype wire

// file: sim/oel_event_latch_test.sv
// oel_event_latch_test: self-checking bench for the event latch
// assumes oel_remote as far side and the bound checker
`timescale 1ns/1ns
`default_nettype none

module oel_event_latch_test
    import oel_pkg::*;
;
    logic        mclk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    oel_pins_t   pins;
    logic        timer_timeout;
    logic        irq;
    int          miscompares;
    int          tests_run;
    integer      seed;
    logic [31:0] rnd;
    logic [33:0] note;
    logic [33:0] notes[$];

    oel_event_latch #(.SE0_CYCLES(17'd20), .IDLE_CYCLES(17'd30)) oel_event_latch_inst (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .timer_timeout(timer_timeout), .irq(irq)
    );
    oel_remote oel_remote_inst (.mclk(mclk), .pins(pins));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        notes.push_back({!wr, err, exp});
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic irq_is(input logic v);
        repeat (3) @(posedge mclk);
        check("irq", {31'h0, v}, {31'h0, irq});
    endtask : irq_is

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // oldest note against each answer
    always @(posedge mclk) begin
        if (pready === 1'b1) begin
            note = notes.pop_front();
            check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
            if (note[33]) check("prdata", note[31:0], prdata);
        end
    end

    initial begin
        #(50 * 5000);
        miscompares++;
        stop_test();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 32'h4eee;
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, timer_timeout} = '0;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(8'h68, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h00, 32'h0);
        $display("test reset over");
        apb(1'b1, 8'h68, 32'hffff, 32'h0, 1'b1);
        apb(1'b0, 8'he8, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h69, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h08, 32'h3f, 32'h0, 1'b1);
        rnd = $random(seed);
        wr(8'h04, rnd);
        rd(8'h04, rnd & 32'h7ff);
        wr(8'h00, 32'h200);
        rd(8'h00, 32'h200);
        $display("test access over");
        wr(8'h04, 32'h7ff);
        @(posedge mclk);
        timer_timeout <= 1'b1;
        rd(8'h68, 32'h400);
        timer_timeout <= 1'b0;
        irq_is(1'b1);
        wr(8'he8, 32'h3ff);
        rd(8'h68, 32'h400);
        wr(8'h04, 32'h0);
        irq_is(1'b0);
        wr(8'h04, 32'h7ff);
        irq_is(1'b1);
        wr(8'he8, 32'h400);
        irq_is(1'b0);
        rd(8'h68, 32'h0);
        $display("test timer over");
        for (int i = 0; i < 6; i++) begin
            oel_remote_inst.live_flip(i);
            repeat (6) @(posedge mclk);
            rd(8'h68, (32'h1 << i) | (i == 3 ? 32'h100 : 32'h0));
            wr(8'he8, 32'h1ff);
        end
        rd(8'h08, 32'h3f);
        wr(8'h00, 32'h0);
        oel_remote_inst.line_set(OEL_J);
        repeat (6) @(posedge mclk);
        rd(8'h68, 32'h100);
        oel_remote_inst.line_set(OEL_K);
        wr(8'he8, 32'h100);
        wr(8'h00, 32'h200);
        oel_remote_inst.line_set(OEL_J);
        repeat (40) @(posedge mclk);
        rd(8'h68, 32'h040);
        wr(8'he8, 32'h040);
        oel_remote_inst.line_set(OEL_K);
        repeat (6) @(posedge mclk);
        rd(8'h68, 32'h080);
        wr(8'he8, 32'h080);
        $display("test session over");
        oel_remote_inst.line_set(OEL_SE0);
        repeat (18) @(posedge mclk);
        oel_remote_inst.line_set(OEL_K);
        repeat (6) @(posedge mclk);
        rd(8'h68, 32'h0);
        oel_remote_inst.line_set(OEL_SE0);
        repeat (30) @(posedge mclk);
        oel_remote_inst.line_set(OEL_K);
        repeat (6) @(posedge mclk);
        rd(8'h68, 32'h200);
        $display("test line over");
        repeat (3) @(posedge mclk);
        stop_test();
    end
endmodule : oel_event_latch_test
`default_nettype wire
